//--- hdl/lcdc_core.sv
`include "lcdc_params.svh"
`default_nettype none

module lcdc_core #(
  parameter int unsigned OSC_HALF = `LCDC_OSC_HALF,
  parameter int unsigned NUM_SEG = `LCDC_NUM_SEG
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clock source pins
  input wire logic oscillator_select_pin,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe,
  // Cascade sync pin, open drain
  input wire logic sync_pin_i,
  output logic sync_pin_o,
  output logic sync_pin_oe,
  // LCD drive levels, two bits per electrode
  output logic [2*`LCDC_NUM_BP-1:0] backplane_outputs,
  output logic [2*NUM_SEG-1:0] segment_outputs,
  output logic bias_centre_bypass
);

  localparam int unsigned OSC_W = $clog2(OSC_HALF + 1);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (OSC_HALF < 4 || NUM_SEG < 1 || NUM_SEG > `LCDC_NUM_SEG)
  begin : g_chk
    $error("lcdc_core: unsupported oscillator divider or segment count");
  end

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Active backplane slot for a frame phase
  function automatic logic [1:0] lcdc_slot(input logic [4:0] ph, input lcdc_pkg::lcdc_mode_t md);
    logic [4:0] p;
    p = (ph >= `LCDC_HALF_PHASE) ? ph - `LCDC_HALF_PHASE : ph;
    unique case (md)
      `LCDC_MODE_STATIC: lcdc_slot = 2'h0;
      `LCDC_MODE_MUX2: lcdc_slot = (p >= 5'h06) ? 2'h1 : 2'h0;
      `LCDC_MODE_MUX3: lcdc_slot = (p >= 5'h08) ? 2'h2 : (p >= 5'h04) ? 2'h1 : 2'h0;
      `LCDC_MODE_MUX4: lcdc_slot = (p >= 5'h09) ? 2'h3 : (p >= 5'h06) ? 2'h2 : (p >= 5'h03) ? 2'h1 : 2'h0;
    endcase
  endfunction : lcdc_slot

  // Slot each backplane pin follows; spare pins mirror used ones
  function automatic logic [1:0] lcdc_bp_row(input logic [1:0] idx, input lcdc_pkg::lcdc_mode_t md);
    unique case (md)
      `LCDC_MODE_STATIC: lcdc_bp_row = 2'h0;
      `LCDC_MODE_MUX2: lcdc_bp_row = {1'b0, idx[0]};
      `LCDC_MODE_MUX3: lcdc_bp_row = (idx == 2'h3) ? 2'h1 : idx;
      `LCDC_MODE_MUX4: lcdc_bp_row = idx;
    endcase
  endfunction : lcdc_bp_row

  // Backplane level: selected swings rail to rail, others sit at bias
  function automatic lcdc_pkg::lcdc_level_t lcdc_bp_lvl(input logic sel, input logic pol, input logic half);
    if (sel)
      lcdc_bp_lvl = pol ? `LCDC_LVL_VLCD : `LCDC_LVL_VSS;
    else if (half)
      lcdc_bp_lvl = `LCDC_LVL_LOW;
    else
      lcdc_bp_lvl = pol ? `LCDC_LVL_LOW : `LCDC_LVL_HIGH;
  endfunction : lcdc_bp_lvl

  // Segment level: on opposes selected backplane, off follows bias
  function automatic lcdc_pkg::lcdc_level_t lcdc_seg_lvl(input logic on, input logic pol, input logic two);
    if (on)
      lcdc_seg_lvl = pol ? `LCDC_LVL_VSS : `LCDC_LVL_VLCD;
    else if (two)
      lcdc_seg_lvl = pol ? `LCDC_LVL_VLCD : `LCDC_LVL_VSS;
    else
      lcdc_seg_lvl = pol ? `LCDC_LVL_HIGH : `LCDC_LVL_LOW;
  endfunction : lcdc_seg_lvl

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0] osc_sync_r, clkin_sync_r, sync_sync_r;
  logic clkin_prev_r, sync_prev_r;
  logic [2:0] sync_oe_hist_r;
  logic [OSC_W-1:0] osc_cnt_r;
  logic [4:0] phase_r, phase_nxt;
  logic [5:0] frame_cnt_r;
  logic [1:0] row_d_r;
  logic pol_d_r;
  logic disp_en_r, blink_r, bias_half_r, bank_in_r, bank_out_r;
  lcdc_pkg::lcdc_mode_t mode_r;
  logic [`LCDC_SEG_AW-1:0] ptr_r;
  logic aw_hold_r, w_hold_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [NUM_SEG-1:0] rd_data;
  logic [2*`LCDC_NUM_BP-1:0] bp_nxt;
  logic [2*NUM_SEG-1:0] seg_nxt;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_sync_r <= 2'h0;
      clkin_sync_r <= 2'h0;
      sync_sync_r <= 2'h3;
      clkin_prev_r <= 1'b0;
      sync_prev_r <= 1'b1;
    end
    else
    begin
      osc_sync_r <= {osc_sync_r[0], oscillator_select_pin};
      clkin_sync_r <= {clkin_sync_r[0], clk_pin_i};
      sync_sync_r <= {sync_sync_r[0], sync_pin_i};
      clkin_prev_r <= clkin_sync_r[1];
      sync_prev_r <= sync_sync_r[1];
    end
  end

  // ----------------------------------------
  // Clock source and frame phase
  // ----------------------------------------
  // Tick select, oscillator wrap, sync detect
  wire ext_sel = osc_sync_r[1];
  wire ext_edge = clkin_sync_r[1] & ~clkin_prev_r;
  wire osc_wrap = osc_cnt_r == OSC_W'(OSC_HALF - 1);
  wire int_tick = osc_wrap & ~clk_pin_o;
  wire tick = ext_sel ? ext_edge : int_tick;
  wire sync_hit = sync_prev_r & ~sync_sync_r[1] & ~sync_pin_oe & ~(|sync_oe_hist_r);
  wire frame_end = tick & (phase_r == `LCDC_PHASE_LAST);
  assign phase_nxt = sync_hit ? 5'h00 : frame_end ? 5'h00 : tick ? phase_r + 5'h01 : phase_r;

  // Internal oscillator, driven out for cascaded parts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_cnt_r <= '0;
      clk_pin_o <= 1'b0;
      clk_pin_oe <= 1'b0;
    end
    else
    begin
      osc_cnt_r <= osc_wrap ? '0 : osc_cnt_r + OSC_W'(1);
      clk_pin_o <= osc_wrap ? ~clk_pin_o : clk_pin_o;
      clk_pin_oe <= ~ext_sel;
    end
  end

  // Frame phase, frame count and sync pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_r <= 5'h00;
      frame_cnt_r <= 6'h00;
      sync_pin_o <= 1'b0;
      sync_pin_oe <= 1'b0;
      sync_oe_hist_r <= 3'h0;
    end
    else
    begin
      phase_r <= phase_nxt;
      frame_cnt_r <= frame_end ? frame_cnt_r + 6'h01 : frame_cnt_r;
      sync_pin_o <= 1'b0;
      sync_pin_oe <= phase_nxt == 5'h00;
      sync_oe_hist_r <= {sync_oe_hist_r[1:0], sync_pin_oe};
    end
  end

  // ----------------------------------------
  // Display RAM and scan pipeline
  // ----------------------------------------
  // Plane fetch with output bank selection
  wire low_mux = (mode_r == `LCDC_MODE_STATIC) | (mode_r == `LCDC_MODE_MUX2);
  wire [1:0] row_now = lcdc_slot(phase_r, mode_r);
  wire [1:0] rd_plane = (low_mux & bank_out_r) ? row_now + 2'h2 : row_now;
  wire [1:0] wr_plane_raw = wdata_r[`LCDC_RAMWR_PLANE +: 2];
  wire [`LCDC_SEG_AW-1:0] wr_seg = wdata_r[`LCDC_RAMWR_SEG +: `LCDC_SEG_AW];

  // Write decode
  wire do_write = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire sel_ctrl = awaddr_r == `LCDC_CTRL_OFF;
  wire sel_ram = awaddr_r == `LCDC_RAMWR_OFF;
  wire ram_we = do_write & sel_ram & (wstrb_r == 4'hf) & (wr_seg < `LCDC_SEG_AW'(NUM_SEG));
  wire [1:0] ram_wplane = (low_mux & bank_in_r) ? wr_plane_raw + 2'h2 : wr_plane_raw;

  lcdc_plane_ram #(
    .WIDTH(NUM_SEG),
    .DEPTH(`LCDC_NUM_BP),
    .AW(`LCDC_SEG_AW)
  ) i_lcdc_plane_ram (
    .aclk(aclk),
    .wr_en(ram_we),
    .wr_plane(ram_wplane),
    .wr_bit(wr_seg),
    .wr_val(wdata_r[`LCDC_RAMWR_VAL]),
    .rd_plane(rd_plane),
    .rd_data(rd_data)
  );

  // Slot and polarity aligned with the plane read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      row_d_r <= 2'h0;
      pol_d_r <= 1'b0;
    end
    else
    begin
      row_d_r <= row_now;
      pol_d_r <= phase_r >= `LCDC_HALF_PHASE;
    end
  end

  // Level selection for every electrode
  wire blank = ~disp_en_r | (blink_r & frame_cnt_r[`LCDC_BLINK_BIT]);
  wire two_lvl = bias_half_r | (mode_r == `LCDC_MODE_STATIC);
  always_comb
  begin
    for (int i = 0; i < `LCDC_NUM_BP; i++)
    begin
      bp_nxt[2*i +: 2] = blank ? `LCDC_LVL_VLCD :
        lcdc_bp_lvl(lcdc_bp_row(2'(i), mode_r) == row_d_r, pol_d_r, bias_half_r);
    end
    for (int s = 0; s < NUM_SEG; s++)
    begin
      seg_nxt[2*s +: 2] = blank ? `LCDC_LVL_VLCD : lcdc_seg_lvl(rd_data[s], pol_d_r, two_lvl);
    end
  end

  // Output registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      backplane_outputs <= {`LCDC_NUM_BP{`LCDC_LVL_VLCD}};
      segment_outputs <= {NUM_SEG{`LCDC_LVL_VLCD}};
      bias_centre_bypass <= 1'b0;
    end
    else
    begin
      backplane_outputs <= bp_nxt;
      segment_outputs <= seg_nxt;
      bias_centre_bypass <= bias_half_r & (mode_r != `LCDC_MODE_STATIC);
    end
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  // Control register and write pointer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      disp_en_r <= 1'b0;
      blink_r <= 1'b0;
      mode_r <= `LCDC_MODE_RST;
      bias_half_r <= 1'b0;
      bank_in_r <= 1'b0;
      bank_out_r <= 1'b0;
      ptr_r <= '0;
    end
    else
    begin
      if (do_write & sel_ctrl & wstrb_r[0])
      begin
        disp_en_r <= wdata_r[`LCDC_CTRL_EN];
        blink_r <= wdata_r[`LCDC_CTRL_BLINK];
        mode_r <= wdata_r[`LCDC_CTRL_MODE +: 2];
        bias_half_r <= wdata_r[`LCDC_CTRL_BIAS];
        bank_in_r <= wdata_r[`LCDC_CTRL_BANK_IN];
        bank_out_r <= wdata_r[`LCDC_CTRL_BANK_OUT];
      end
      if (ram_we)
      begin
        ptr_r <= wr_seg;
      end
    end
  end

  // Channel handshakes
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire aw_hold_nxt = aw_take | (aw_hold_r & ~do_write);
  wire w_hold_nxt = w_take | (w_hold_r & ~do_write);
  wire rvalid_nxt = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire wr_ok = sel_ctrl | sel_ram;
  wire rd_ok = (s_axi_araddr == `LCDC_CTRL_OFF) | (s_axi_araddr == `LCDC_RAMWR_OFF) |
    (s_axi_araddr == `LCDC_STATUS_OFF);

  // Read data selection
  wire [31:0] ctrl_word = {25'h0, bank_out_r, bank_in_r, bias_half_r, mode_r, blink_r, disp_en_r};
  wire [31:0] stat_word = {18'h0, pol_d_r, ext_sel, 2'h0, row_d_r, 3'h0, phase_r};
  wire [31:0] rd_word = (s_axi_araddr == `LCDC_CTRL_OFF) ? ctrl_word :
    (s_axi_araddr == `LCDC_RAMWR_OFF) ? {26'h0, ptr_r} :
    (s_axi_araddr == `LCDC_STATUS_OFF) ? stat_word : 32'h0;

  // Write channel capture and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LCDC_RESP_OKAY;
    end
    else
    begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= aw_take ? s_axi_awaddr : awaddr_r;
      wdata_r <= w_take ? s_axi_wdata : wdata_r;
      wstrb_r <= w_take ? s_axi_wstrb : wstrb_r;
      s_axi_awready <= ~aw_hold_nxt;
      s_axi_wready <= ~w_hold_nxt;
      s_axi_bvalid <= do_write | (s_axi_bvalid & ~s_axi_bready);
      s_axi_bresp <= do_write ? (wr_ok ? `LCDC_RESP_OKAY : `LCDC_RESP_SLVERR) : s_axi_bresp;
    end
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `LCDC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rdata <= ar_take ? rd_word : s_axi_rdata;
      s_axi_rresp <= ar_take ? (rd_ok ? `LCDC_RESP_OKAY : `LCDC_RESP_SLVERR) : s_axi_rresp;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence internal_tick_s;
    !ext_sel && int_tick;
  endsequence

  sequence frame_last_s;
    tick && phase_r == `LCDC_PHASE_LAST && !sync_hit;
  endsequence

  sequence mode_steady_s;
    $past(mode_r) == $past(mode_r, 2);
  endsequence

  reset_cfg_a: assert property (@(posedge aclk)
    !aresetn |=> (mode_r == `LCDC_MODE_MUX4 && !bias_half_r && !blink_r && !disp_en_r && !bank_in_r && !bank_out_r
      && ptr_r == '0))
    else $error("configuration not at reset defaults");

  disp_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !disp_en_r |=> (backplane_outputs == {`LCDC_NUM_BP{`LCDC_LVL_VLCD}}
      && segment_outputs == {NUM_SEG{`LCDC_LVL_VLCD}}))
    else $error("outputs left supply level while display off");

  int_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
    internal_tick_s |=> (clk_pin_o && clk_pin_oe))
    else $error("internal clock not driven on clock pin");

  clk_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_sel |=> !clk_pin_oe)
    else $error("clock pin driven while external clock selected");

  frame_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_last_s |=> phase_r == 5'h00)
    else $error("frame did not wrap after twenty-four clocks");

  ext_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ext_sel && ext_edge && !sync_hit && phase_r != `LCDC_PHASE_LAST) |=> phase_r == $past(phase_r) + 5'h01)
    else $error("external clock edge did not advance phase");

  bias_ctrl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (bias_half_r && mode_r != `LCDC_MODE_STATIC) |=> bias_centre_bypass)
    else $error("half bias without centre bypass");

  static_bp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_r == `LCDC_MODE_STATIC |=> (backplane_outputs[1:0] == backplane_outputs[3:2]
      && backplane_outputs[1:0] == backplane_outputs[5:4] && backplane_outputs[1:0] == backplane_outputs[7:6]))
    else $error("static mode backplanes differ");

  mirror_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_r == `LCDC_MODE_MUX3 |=> backplane_outputs[7:6] == backplane_outputs[3:2])
    else $error("spare backplane does not mirror second backplane in 1:3");

  row_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($changed(row_d_r) ##0 mode_steady_s) |-> (row_d_r == 2'h0 || row_d_r == $past(row_d_r) + 2'h1))
    else $error("backplane scan not ascending");

endmodule : lcdc_core

`default_nettype wire

//--- pkg/lcdc_params.svh
`ifndef LCDC_PARAMS_SVH
`define LCDC_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define LCDC_CLK_HZ 20000000
`define LCDC_FRAME_HZ 64
`define LCDC_FRAME_DIV 24
`define LCDC_OSC_HALF (`LCDC_CLK_HZ / (2 * `LCDC_FRAME_HZ * `LCDC_FRAME_DIV))
`define LCDC_PHASE_LAST 5'h17
`define LCDC_HALF_PHASE 5'h0c
`define LCDC_BLINK_BIT 5

// ----------------------------------------
// Sizes
// ----------------------------------------
`define LCDC_NUM_BP 4
`define LCDC_NUM_SEG 60
`define LCDC_SEG_AW 6

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LCDC_CTRL_OFF 4'h0
`define LCDC_RAMWR_OFF 4'h4
`define LCDC_STATUS_OFF 4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCDC_CTRL_EN 0
`define LCDC_CTRL_BLINK 1
`define LCDC_CTRL_MODE 2
`define LCDC_CTRL_BIAS 4
`define LCDC_CTRL_BANK_IN 5
`define LCDC_CTRL_BANK_OUT 6
`define LCDC_RAMWR_SEG 0
`define LCDC_RAMWR_PLANE 8
`define LCDC_RAMWR_VAL 16

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define LCDC_MODE_STATIC 2'h0
`define LCDC_MODE_MUX2 2'h1
`define LCDC_MODE_MUX3 2'h2
`define LCDC_MODE_MUX4 2'h3
`define LCDC_MODE_RST 2'h3
`define LCDC_LVL_VSS 2'h0
`define LCDC_LVL_LOW 2'h1
`define LCDC_LVL_HIGH 2'h2
`define LCDC_LVL_VLCD 2'h3
`define LCDC_RESP_OKAY 2'h0
`define LCDC_RESP_SLVERR 2'h2

`endif

//--- pkg/lcdc_pkg.sv
`default_nettype none

package lcdc_pkg;
  // Two-bit drive level: 0 ground, 1 lower bias, 2 upper bias, 3 LCD supply
  typedef logic [1:0] lcdc_level_t;
  // Drive mode: static, 1:2, 1:3, 1:4
  typedef logic [1:0] lcdc_mode_t;
endpackage : lcdc_pkg

`default_nettype wire

//--- hdl/lcdc_plane_ram.sv
`include "lcdc_params.svh"
`default_nettype none

module lcdc_plane_ram #(
  parameter int unsigned WIDTH = `LCDC_NUM_SEG,
  parameter int unsigned DEPTH = `LCDC_NUM_BP,
  parameter int unsigned AW = `LCDC_SEG_AW
)
(
  // Clock
  input wire logic aclk,
  // Write one bit of one plane
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_plane,
  input wire logic [AW-1:0] wr_bit,
  input wire logic wr_val,
  // Read a whole plane, registered
  input wire logic [$clog2(DEPTH)-1:0] rd_plane,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (WIDTH > (1 << AW) || DEPTH < 2)
  begin : g_chk
    $error("lcdc_plane_ram: width does not fit bit address");
  end

  // Bit write and registered plane read
  always_ff @(posedge aclk)
  begin
    if (wr_en)
    begin
      mem_r[wr_plane][wr_bit] <= wr_val;
    end
    rd_data <= mem_r[rd_plane];
  end

endmodule : lcdc_plane_ram

`default_nettype wire

//--- test/lcdc_panel.sv
`default_nettype none

module lcdc_panel
(
  // Clock
  input wire logic aclk,
  // Backplane electrode levels
  input wire logic [7:0] backplane_outputs,
  // Scan observations
  output int steps,
  output int skips
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [1:0] sel_idx;
  logic [1:0] last_idx = 2'h0;
  int steps_r = 0;
  int skips_r = 0;

  // Observation counters, one driver each
  assign steps = steps_r;
  assign skips = skips_r;

  // Selected plate sits at an outer level, the others at bias levels
  always_comb
  begin
    sel_idx = 2'h0;
    for (int i = 3; i >= 0; i--)
      if (backplane_outputs[2*i+:2] inside {2'h0, 2'h3})
        sel_idx = 2'(i);
  end

  // Count scan steps and any step that is not to the next plate
  always @(posedge aclk)
  begin
    last_idx <= sel_idx;
    if (sel_idx != last_idx)
    begin
      steps_r <= steps_r + 1;
      if (sel_idx != last_idx + 2'h1)
        skips_r <= skips_r + 1;
    end
  end
endmodule : lcdc_panel

`default_nettype wire

//--- test/lcd_drive_mode_clock_control_test.sv
`default_nettype none

module lcd_drive_mode_clock_control_test;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, ext_cnt = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic osc_sel = 1'b0, ext_clk = 1'b0, last_oe = 1'b0, ext_sync_n = 1'b1, last_clk = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, clk_o, clk_oe, sync_o, sync_oe, bypass;
  logic [1:0] bresp, rresp;
  logic [7:0] bp;
  logic [119:0] seg;
  wire logic clk_wire, sync_wire;
  int steps, skips, num_errors = 0, check_count = 0, clk_rises = 0;

  // Pin levels from all drivers; sync has a pull-up
  assign clk_wire = clk_oe ? clk_o : ext_clk;
  assign sync_wire = (sync_oe ? sync_o : 1'b1) & ext_sync_n;

  lcdc_core #(.OSC_HALF(4)) i_lcdc_core (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .oscillator_select_pin(osc_sel), .clk_pin_i(clk_wire), .clk_pin_o(clk_o), .clk_pin_oe(clk_oe),
    .sync_pin_i(sync_wire), .sync_pin_o(sync_o), .sync_pin_oe(sync_oe),
    .backplane_outputs(bp), .segment_outputs(seg), .bias_centre_bypass(bypass));

  lcdc_panel i_lcdc_panel (.aclk(aclk), .backplane_outputs(bp), .steps(steps), .skips(skips));

  // Clock never stops
  initial
    forever #25 aclk = ~aclk;

  // External clock of ten cycles, sync edge history, clock pin rises
  always @(posedge aclk)
  begin
    last_oe <= sync_oe;
    last_clk <= clk_o;
    if (clk_o && !last_clk)
      clk_rises <= clk_rises + 1;
    ext_cnt <= (ext_cnt == 4'h4) ? 4'h0 : ext_cnt + 4'h1;
    if (ext_cnt == 4'h4)
      ext_clk <= ~ext_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task conclude;
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    if (n == 100)
    begin
      num_errors++;
      conclude();
    end
    chk(32'(bresp), 32'(er));
  endtask : wr

  task rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rready <= 1'b0;
    d = rdata;
    if (n == 100)
    begin
      num_errors++;
      conclude();
    end
    chk(32'(rresp), 32'(er));
  endtask : rd

  // Cycles until the next start of frame
  task next_rise(output int n);
    n = 0;
    @(posedge aclk);
    while (!(sync_oe === 1'b1 && last_oe === 1'b0))
    begin
      @(posedge aclk);
      n++;
      if (n > 3000)
      begin
        num_errors++;
        conclude();
      end
    end
  endtask : next_rise

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    int n, s0, k0, r0;
    logic [31:0] d;
    logic [7:0] e;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(32'(bp), 32'hff);
    chk(32'(&seg), 32'h1);
    chk(32'(clk_oe), 32'h1);
    rd(4'h0, 2'h0, d);
    chk(d, 32'hc);
    rd(4'h4, 2'h0, d);
    chk(d, 32'h0);
    rd(4'hc, 2'h2, d);
    chk(d, 32'h0);
    wr(4'h8, 32'h1, 2'h2);
    wr(4'h4, 32'h00010105, 2'h0);
    rd(4'h4, 2'h0, d);
    chk(d, 32'h5);
    // Every drive mode, display on
    for (int m = 0; m < 4; m++)
    begin
      wr(4'h0, 32'(m * 4 + 1), 2'h0);
      rd(4'h0, 2'h0, d);
      chk(d, 32'(m * 4 + 1));
      repeat (100) @(posedge aclk);
      e = (m == 0) ? {4{bp[1:0]}} : (m == 1) ? {2{bp[3:0]}} : (m == 2) ? {bp[3:2], bp[5:0]} : bp;
      chk(32'(bp), 32'(e));
      // First slot of the positive half: backplane 0 and its mirrors at ground, others at upper bias
      next_rise(n);
      repeat (4) @(posedge aclk);
      chk(32'(bp), (m == 0) ? 32'h00 : (m == 1) ? 32'h88 : 32'ha8);
      chk(32'(bp == 8'hff), 32'h0);
      if (m == 0)
        chk(32'(bp[1:0] inside {2'h1, 2'h2}), 32'h0);
      if (m == 3)
      begin
        // Second slot: the segment written in plane 1 is on
        repeat (30) @(posedge aclk);
        chk(32'(seg[11:10]), 32'h3);
        chk(32'(bp), 32'ha2);
      end
    end
    // Frame length and ascending scan from internal oscillator
    next_rise(n);
    s0 = steps;
    k0 = skips;
    r0 = clk_rises;
    next_rise(n);
    chk(32'(n), 32'd191);
    chk(32'(clk_rises - r0), 32'd24);
    chk(32'(steps - s0), 32'd8);
    chk(32'(skips - k0), 32'd0);
    // Bias selection across modes
    wr(4'h0, 32'h1d, 2'h0);
    repeat (3) @(posedge aclk);
    chk(32'(bypass), 32'h1);
    wr(4'h0, 32'h15, 2'h0);
    repeat (3) @(posedge aclk);
    chk(32'(bypass), 32'h1);
    wr(4'h0, 32'h11, 2'h0);
    repeat (3) @(posedge aclk);
    chk(32'(bypass), 32'h0);
    wr(4'h0, 32'h0d, 2'h0);
    repeat (3) @(posedge aclk);
    chk(32'(bypass), 32'h0);
    // Display off blanks everything
    wr(4'h0, 32'hc, 2'h0);
    repeat (3) @(posedge aclk);
    chk(32'(bp), 32'hff);
    chk(32'(&seg), 32'h1);
    wr(4'h0, 32'hd, 2'h0);
    // A cascade partner pulling sync restarts the frame
    next_rise(n);
    repeat (50) @(posedge aclk);
    ext_sync_n <= 1'b0;
    next_rise(n);
    ext_sync_n <= 1'b1;
    chk(32'(n < 8), 32'h1);
    chk(32'(sync_o), 32'h0);
    // External clock takes over timing
    osc_sel <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(32'(clk_oe), 32'h0);
    rd(4'h8, 2'h0, d);
    chk(32'(d[12]), 32'h1);
    next_rise(n);
    next_rise(n);
    chk(32'(n), 32'd239);
    conclude();
  end
endmodule : lcd_drive_mode_clock_control_test

`default_nettype wire
